// File: verilog/calib_odt_pkg.sv
// Package for the calibration-invert and command-bus termination registers.
// Assumes one mode-register command port and one clock domain.
package calib_odt_pkg;

   // ======================================================================
   // Mode addresses and register layout
   // ======================================================================
   localparam logic [5:0] ADDR_UPPER_INVERT  = 6'h14;
   localparam logic [5:0] ADDR_VENDOR        = 6'h15;
   localparam logic [5:0] ADDR_TERM_CTRL     = 6'h16;
   localparam logic [5:0] ADDR_PATTERN_A     = 6'h20;
   localparam logic [5:0] ADDR_PATTERN_B     = 6'h28;

   // Reset values
   localparam logic [7:0] UPPER_INVERT_RST   = 8'h55;
   localparam logic [7:0] TERM_CTRL_RST      = 8'h00;
   localparam logic [7:0] PATTERN_A_RST      = 8'h5A;
   localparam logic [7:0] PATTERN_B_RST      = 8'h3C;
   // Arbitrary neutral content for the vendor register
   localparam logic [7:0] VENDOR_RST         = 8'h00;

   // Termination-control field positions
   localparam int CTRL_TERM_LSB   = 0;
   localparam int CTRL_TERM_MSB   = 2;
   localparam int CK_OVR_BIT      = 3;
   localparam int CS_OVR_BIT      = 4;
   localparam int CA_DIS_BIT      = 5;
   localparam logic [2:0] CTRL_TERM_OFF = 3'h0;
   localparam logic [2:0] CTRL_TERM_RFU = 3'h7;
   localparam logic [2:0] CMD_TERM_OFF  = 3'h0;

   // Multipurpose command opcode that requests calibration readout
   localparam logic [6:0] MPC_READ_CALIB = 7'h43;
   // Beats per pattern in the readout burst
   localparam logic [3:0] BEATS_PER_PAT  = 4'h8;

   // Mode-register command carried on one port
   typedef struct packed {
      logic       write;
      logic       read;
      logic [5:0] addr;
      logic [7:0] data;
   } mr_cmd_s;

   // Termination enables towards the pad drivers
   typedef struct packed {
      logic [2:0] level;
      logic       ck;
      logic       cs;
      logic [5:0] ca;
   } term_out_s;

endpackage

// File: verilog/set_point_store.sv
// Two copies of the termination-control byte, one per frequency set point.
// Assumes writes arrive one per cycle, on the system clock.
module set_point_store (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Write and access-copy select
   input  wire logic       wrEn,
   input  wire logic       wrSel,
   input  wire logic [7:0] wrData,
   // Operating copy select
   input  wire logic       opSel,
   // Registered outputs
   output logic [7:0]      accessData,
   output logic [7:0]      operData
);
   import calib_odt_pkg::*;

   logic [7:0] copy_reg [2];

   // =====================================================================
   // Storage
   // =====================================================================
   // Only the copy named by the write select is touched
   always_ff @(posedge clk) begin
      if (rst) begin
         copy_reg[0] <= TERM_CTRL_RST;
         copy_reg[1] <= TERM_CTRL_RST;
      end else if (wrEn) begin
         copy_reg[wrSel] <= wrData;
      end
   end

   // Read data out of registers; one cycle behind the copies
   always_ff @(posedge clk) begin
      if (rst) begin
         accessData <= TERM_CTRL_RST;
         operData   <= TERM_CTRL_RST;
      end else begin
         accessData <= copy_reg[wrSel];
         operData   <= copy_reg[opSel];
      end
   end

endmodule // set_point_store

// File: verilog/calib_odt_regs.sv
// Calibration-invert and command-bus termination mode registers.
// Assumes decoded mode-register and multipurpose commands on clk,
// and a command-termination pad that arrives asynchronously.
//
// Operation
// - Invert bit set flips its upper lane
// - Bits 0-7 map to lanes 8-15
// - Invert register resets to 55 hex
// - Upper mask lane never inverted
// - No bus inversion during calibration readout
// - Invert register write-only at 14 hex
// - 15 hex is vendor-specific register
// - Termination register at 16 hex, resets 0
// - Controller termination code, 111 reserved
// - Clock override terminates clock inputs
// - Chip-select override terminates chip select
// - CA terminates on pad high, valid setting
// - CA disable bit forces termination off
// - Access reaches write-set-point copy only
// - Operation uses operating-set-point copy only
// - Termination holds in all power states
// - Calibration readout returns A then B
// - Patterns reset to 5A and 3C
module calib_odt_regs (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Mode-register command port
   input  wire calib_odt_pkg::mr_cmd_s  mrCmd,
   output logic                         mrReadValid,
   output logic [7:0]                   mrReadData,
   // Multipurpose command port
   input  wire logic                    mpcValid,
   input  wire logic [6:0]              mpcOp,
   // Settings held in other mode registers
   input  wire logic [2:0]              commandBusTerminationSetting,
   input  wire logic                    writeSetPointSelect,
   input  wire logic                    operatingSetPointSelect,
   input  wire logic                    readDbiEnable,
   input  wire logic [7:0]              lowerByteCalibInvert,
   // Pad
   input  wire logic                    commandTerminationPad,
   // Calibration readout
   output logic                         calibValid,
   output logic [7:0]                   calibLowerDq,
   output logic [7:0]                   calibUpperDq,
   output logic [1:0]                   calibMaskLane,
   output logic                         calibDbiActive,
   // Termination control
   output calib_odt_pkg::term_out_s     termOut,
   output logic                         controllerTermReserved
);
   import calib_odt_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_PAT_A = 3'b010,
      ST_PAT_B = 3'b100
   } burst_e;

   logic [7:0] upperInvert_reg;
   logic [7:0] vendor_reg;
   logic [7:0] patternA_reg;
   logic [7:0] patternB_reg;
   logic [7:0] termAccess;
   logic [7:0] termOper;
   logic       padMeta_reg;
   logic       padSync_reg;
   logic       termWrite;
   logic       rdPending_reg;
   logic [7:0] rdData_next;
   burst_e     burst_reg;
   burst_e     burst_next;
   logic [3:0] beat_reg;
   logic       cmdTermValid;
   logic       caTerm;

   // One lane byte of readout: pattern XOR mask, no bus inversion
   function automatic logic [7:0] calib_byte(input logic [7:0] pat,
                                             input logic [7:0] mask);
      return pat ^ mask;
   endfunction

   // =====================================================================
   // Register writes
   // =====================================================================
   // invert write
   always_ff @(posedge clk) begin
      if (rst)
         upperInvert_reg <= UPPER_INVERT_RST;
      else if (mrCmd.write && mrCmd.addr == ADDR_UPPER_INVERT)
         upperInvert_reg <= mrCmd.data;
   end

   always_ff @(posedge clk) begin
      if (rst)
         vendor_reg <= VENDOR_RST;
      else if (mrCmd.write && mrCmd.addr == ADDR_VENDOR)
         vendor_reg <= mrCmd.data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         patternA_reg <= PATTERN_A_RST;
         patternB_reg <= PATTERN_B_RST;
      end else if (mrCmd.write) begin
         if (mrCmd.addr == ADDR_PATTERN_A)
            patternA_reg <= mrCmd.data;
         else if (mrCmd.addr == ADDR_PATTERN_B)
            patternB_reg <= mrCmd.data;
      end
   end

   // byte-select bits stored as written; controller keeps them zero
   assign termWrite = mrCmd.write && (mrCmd.addr == ADDR_TERM_CTRL);

   set_point_store uStore (
      .clk        (clk),
      .rst        (rst),
      .wrEn       (termWrite),
      .wrSel      (writeSetPointSelect),
      .wrData     (mrCmd.data),
      .opSel      (operatingSetPointSelect),
      .accessData (termAccess),
      .operData   (termOper)
   );

   // =====================================================================
   // Mode-register read
   // =====================================================================
   // Answer comes two cycles after the request so the store can settle;
   // the invert register is write-only and reads back as zero.
   always_comb begin
      rdData_next = 8'h00;
      if (mrCmd.addr == ADDR_VENDOR)
         rdData_next = vendor_reg;
      else if (mrCmd.addr == ADDR_TERM_CTRL)
         rdData_next = 8'h00;
   end

   logic [5:0] rdAddr_reg;
   logic [7:0] rdHold_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         rdPending_reg <= 1'b0;
         rdAddr_reg    <= 6'h00;
         rdHold_reg    <= 8'h00;
      end else begin
         rdPending_reg <= mrCmd.read;
         rdAddr_reg    <= mrCmd.addr;
         rdHold_reg    <= rdData_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mrReadValid <= 1'b0;
         mrReadData  <= 8'h00;
      end else begin
         mrReadValid <= rdPending_reg;
         if (rdPending_reg)
            mrReadData <= (rdAddr_reg == ADDR_TERM_CTRL) ? termAccess
                                                         : rdHold_reg;
      end
   end

   // =====================================================================
   // Calibration readout burst
   // =====================================================================
   // A then B
   always_comb begin
      burst_next = burst_reg;
      case (burst_reg)
         ST_IDLE:
            if (mpcValid && mpcOp == MPC_READ_CALIB)
               burst_next = ST_PAT_A;
         ST_PAT_A:
            if (beat_reg == BEATS_PER_PAT - 4'h1)
               burst_next = ST_PAT_B;
         ST_PAT_B:
            if (beat_reg == BEATS_PER_PAT - 4'h1)
               burst_next = ST_IDLE;
         default:
            burst_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         burst_reg <= ST_IDLE;
         beat_reg  <= 4'h0;
      end else begin
         burst_reg <= burst_next;
         if (burst_reg == ST_IDLE || beat_reg == BEATS_PER_PAT - 4'h1)
            beat_reg <= 4'h0;
         else
            beat_reg <= beat_reg + 4'h1;
      end
   end

   // Data out of flops; each beat repeats the pattern with masks applied
   always_ff @(posedge clk) begin
      if (rst) begin
         calibValid    <= 1'b0;
         calibLowerDq  <= 8'h00;
         calibUpperDq  <= 8'h00;
         calibMaskLane <= 2'b00;
      end else begin
         calibValid <= (burst_next != ST_IDLE);
         if (burst_next == ST_PAT_A) begin
            calibLowerDq  <= calib_byte(patternA_reg, lowerByteCalibInvert);
            calibUpperDq  <= calib_byte(patternA_reg, upperInvert_reg);
            calibMaskLane <= {patternA_reg[0], patternA_reg[0]};
         end else if (burst_next == ST_PAT_B) begin
            calibLowerDq  <= calib_byte(patternB_reg, lowerByteCalibInvert);
            calibUpperDq  <= calib_byte(patternB_reg, upperInvert_reg);
            calibMaskLane <= {patternB_reg[0], patternB_reg[0]};
         end
      end
   end

   // no inversion: the enable is masked for the whole readout burst
   assign calibDbiActive = readDbiEnable && (burst_reg == ST_IDLE);

   // =====================================================================
   // Termination
   // =====================================================================
   // Pad is asynchronous: two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         padMeta_reg <= 1'b0;
         padSync_reg <= 1'b0;
      end else begin
         padMeta_reg <= commandTerminationPad;
         padSync_reg <= padMeta_reg;
      end
   end

   assign cmdTermValid = (commandBusTerminationSetting != CMD_TERM_OFF);

   assign caTerm = !termOper[CA_DIS_BIT] && padSync_reg && cmdTermValid;

   // no power-state gating: enables depend only on settings and pad
   always_comb begin
      termOut.level = commandBusTerminationSetting;
      termOut.ck    = cmdTermValid && (termOper[CK_OVR_BIT] || padSync_reg);
      termOut.cs    = cmdTermValid && (termOper[CS_OVR_BIT] || padSync_reg);
      termOut.ca    = {6{caTerm}};
   end

   assign controllerTermReserved =
      (termOper[CTRL_TERM_MSB:CTRL_TERM_LSB] == CTRL_TERM_RFU);

endmodule // calib_odt_regs

// File: verif/calib_odt_asserts.sv
// Checker for the calibration and termination register block.
// Sees only top-level ports; bound to the design at the foot.
module calib_odt_asserts
   import calib_odt_pkg::*;
(
   // Clock, reset and requests
   input wire logic      clk,
   input wire logic      rst,
   input wire mr_cmd_s   mrCmd,
   input wire logic      mpcValid,
   input wire logic [6:0] mpcOp,
   input wire logic [2:0] commandBusTerminationSetting,
   // Answers
   input wire logic      mrReadValid,
   input wire logic      calibValid,
   input wire logic [1:0] calibMaskLane,
   input wire logic      calibDbiActive,
   input wire term_out_s termOut
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==================================================================
   // Calibration readout
   sequence startCal;
      mpcValid && mpcOp == MPC_READ_CALIB && !calibValid;
   endsequence
   sequence eightBeats;
      calibValid [*8];
   endsequence
   burst_length_a: assert property (
      startCal |=> eightBeats ##1 eightBeats ##1 !calibValid)
      else $error("calibration burst length wrong");
   burst_cause_a: assert property (
      $rose(calibValid) |-> $past(mpcValid))
      else $error("burst without command");
   no_dbi_a: assert property (
      calibValid |-> calibDbiActive == 1'b0)
      else $error("bus inversion during readout");
   mask_true_a: assert property (
      calibValid |-> calibMaskLane[1] == calibMaskLane[0])
      else $error("mask lane inverted");
   // ==================================================================
   // Register reads: answer exactly two cycles on
   read_answer_a: assert property (
      mrCmd.read |-> ##2 mrReadValid)
      else $error("read answer missing");
   read_cause_a: assert property (
      mrReadValid |-> $past(mrCmd.read, 2))
      else $error("read answer without request");
   // ==================================================================
   // Termination outputs
   term_level_a: assert property (
      termOut.level == commandBusTerminationSetting)
      else $error("termination level mismatch");
   term_valid_a: assert property (
      (|termOut.ca || termOut.ck || termOut.cs) |->
      commandBusTerminationSetting != CMD_TERM_OFF &&
      termOut.ca inside {6'h00, 6'h3F})
      else $error("termination without valid setting");
endmodule // calib_odt_asserts

bind calib_odt_regs calib_odt_asserts calib_odt_asserts_i (
   .clk(clk), .rst(rst), .mrCmd(mrCmd), .mpcValid(mpcValid),
   .mpcOp(mpcOp),
   .commandBusTerminationSetting(commandBusTerminationSetting),
   .mrReadValid(mrReadValid), .calibValid(calibValid),
   .calibMaskLane(calibMaskLane), .calibDbiActive(calibDbiActive),
   .termOut(termOut));

// File: verif/mr_ctrl_model.sv
// Memory-controller model: issues mode-register and multipurpose commands.
// Assumes requests are launched at the falling edge of clk.
module mr_ctrl_model
   import calib_odt_pkg::*;
(
   // Clock and read answer
   input wire logic       clk,
   input wire logic       mrReadValid,
   input wire logic [7:0] mrReadData,
   // Commands towards the device
   output mr_cmd_s        mrCmd,
   output logic           mpcValid,
   output logic [6:0]     mpcOp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mrCmd = '0;
      mpcValid = 1'b0;
      mpcOp = 7'h00;
   end
   // Idle fields flip, so a stale value never passes for a live one
   task automatic idle();
      mrCmd <= '{1'b0, 1'b0, ~mrCmd.addr, ~mrCmd.data};
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      mrCmd <= '{1'b1, 1'b0, a, (a == ADDR_TERM_CTRL) ? (d & 8'h3F) : d};
      @(negedge clk);
      idle();
   endtask
   // Read waits a bounded time for the answer pulse
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      mrCmd <= '{1'b0, 1'b1, a, ~mrCmd.data};
      @(negedge clk);
      idle();
      d = 8'hXX;
      for (n = 0; n < 4 && mrReadValid !== 1'b1; n++) @(negedge clk);
      if (mrReadValid === 1'b1) d = mrReadData;
   endtask
   task automatic multipurpose_command(input logic [6:0] op);
      @(negedge clk);
      mpcValid <= 1'b1;
      mpcOp <= op;
      @(negedge clk);
      mpcValid <= 1'b0;
      mpcOp <= ~op;
   endtask
endmodule // mr_ctrl_model

// File: verif/tb_top.sv
// Self-checking bench for the calibration and termination registers.
// Assumes the controller model drives all command traffic.
module tb_top;
   import calib_odt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] inv, pa, pb, low;} row_s;
   logic       clk = 1'b0, rst = 1'b1, mrReadValid, mpcValid;
   logic       wSel, opSel, dbiEn, pad, calibValid, dbiAct, rsvd;
   logic [2:0] cmdSet;
   logic [6:0] mpcOp;
   logic [7:0] mrReadData, lowInv, lowDq, upDq, rdData;
   logic [1:0] maskLane;
   mr_cmd_s    mrCmd;
   term_out_s  termOut;
   int         failCount = 0, nChecks = 0;
   row_s       rows [4] = '{'{8'h00, 8'hA5, 8'h0F, 8'hFF},
      '{8'hFF, 8'h5A, 8'hC3, 8'h00}, '{8'h15, 8'h01, 8'h80, 8'h15},
      '{8'h55, 8'hFE, 8'h7F, 8'hAA}};
   always #2 clk = ~clk;
   calib_odt_regs calib_odt_regs_i (.clk(clk), .rst(rst), .mrCmd(mrCmd),
      .mrReadValid(mrReadValid), .mrReadData(mrReadData),
      .mpcValid(mpcValid), .mpcOp(mpcOp),
      .commandBusTerminationSetting(cmdSet), .writeSetPointSelect(wSel),
      .operatingSetPointSelect(opSel), .readDbiEnable(dbiEn),
      .lowerByteCalibInvert(lowInv), .commandTerminationPad(pad),
      .calibValid(calibValid), .calibLowerDq(lowDq), .calibUpperDq(upDq),
      .calibMaskLane(maskLane), .calibDbiActive(dbiAct),
      .termOut(termOut), .controllerTermReserved(rsvd));
   mr_ctrl_model mr_ctrl_model_i (.clk(clk), .mrReadValid(mrReadValid),
      .mrReadData(mrReadData), .mrCmd(mrCmd), .mpcValid(mpcValid),
      .mpcOp(mpcOp));
   // ==================================================================
   // Checking helpers
   task automatic chk(input logic [16:0] g, e);
      nChecks++;
      if (g !== e) begin
         failCount++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic term_out_s expTerm(logic [7:0] c, logic p,
                                         logic [2:0] s);
      logic v;
      v = (s != 3'h0);
      return '{s, v & (c[3] | p), v & (c[4] | p), {6{v & p & ~c[5]}}};
   endfunction
   // Sixteen beats: pattern A then B, each lane XOR its mask
   task automatic burst(input logic [7:0] inv, pa, pb);
      logic [7:0] p;
      mr_ctrl_model_i.multipurpose_command(MPC_READ_CALIB);
      // First beat already stands when the command is dropped
      for (int i = 0; i < 16; i++) begin
         p = (i < 8) ? pa : pb;
         chk({calibValid, upDq, lowDq}, {1'b1, p ^ inv, p ^ lowInv});
         chk({maskLane, dbiAct}, {{2{p[0]}}, 1'b0});
         @(negedge clk);
      end
      chk(calibValid, 1'b0);
      chk(dbiAct, dbiEn);
   endtask
   task automatic end_sim();
      if (failCount == 0 && nChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==================================================================
   // Watchdog: whole run needs well under 5000 cycles
   initial begin
      #20000;
      failCount++;
      end_sim();
   end
   initial begin
      {cmdSet, wSel, opSel, pad, lowInv} = '0;
      dbiEn = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      // Rows: invert mask and patterns, lower mask beside them
      foreach (rows[r]) begin
         lowInv = rows[r].low;
         mr_ctrl_model_i.wr(ADDR_UPPER_INVERT, rows[r].inv);
         mr_ctrl_model_i.wr(ADDR_PATTERN_A, rows[r].pa);
         mr_ctrl_model_i.wr(ADDR_PATTERN_B, rows[r].pb);
         burst(rows[r].inv, rows[r].pa, rows[r].pb);
      end
      // Second reset, then defaults and refused reads
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk(termOut, expTerm(8'h00, 1'b0, 3'h0));
      burst(8'h55, 8'h5A, 8'h3C);
      mr_ctrl_model_i.rd(ADDR_TERM_CTRL, rdData);
      chk(rdData, 8'h00);
      mr_ctrl_model_i.rd(ADDR_VENDOR, rdData);
      chk(rdData, VENDOR_RST);
      mr_ctrl_model_i.wr(ADDR_VENDOR, 8'h96);
      mr_ctrl_model_i.rd(ADDR_VENDOR, rdData);
      chk(rdData, 8'h96);
      mr_ctrl_model_i.wr(ADDR_UPPER_INVERT, 8'hF0);
      mr_ctrl_model_i.rd(ADDR_UPPER_INVERT, rdData);
      chk(rdData, 8'h00);
      mr_ctrl_model_i.wr(6'h3F, 8'hFF);
      mr_ctrl_model_i.rd(6'h3F, rdData);
      chk(rdData, 8'h00);
      // Two set-point copies, each reached by the write select
      mr_ctrl_model_i.wr(ADDR_TERM_CTRL, 8'h3B);
      wSel = 1'b1;
      mr_ctrl_model_i.wr(ADDR_TERM_CTRL, 8'hC1);
      mr_ctrl_model_i.rd(ADDR_TERM_CTRL, rdData);
      chk(rdData, 8'h01);
      wSel = 1'b0;
      mr_ctrl_model_i.rd(ADDR_TERM_CTRL, rdData);
      chk(rdData, 8'h3B);
      // Operating copy, pad and setting combinations
      for (int k = 0; k < 8; k++) begin
         {cmdSet[2], pad, opSel} = k[2:0];
         repeat (4) @(negedge clk);
         chk(termOut, expTerm(opSel ? 8'h01 : 8'h3B, pad, cmdSet));
         chk(rsvd, 1'b0);
      end
      wSel = 1'b1;
      mr_ctrl_model_i.wr(ADDR_TERM_CTRL, 8'h07);
      repeat (4) @(negedge clk);
      chk(rsvd, 1'b1);
      opSel = 1'b0;
      repeat (4) @(negedge clk);
      chk(rsvd, 1'b0);
      end_sim();
   end
endmodule // tb_top
